// [dv/host_model.sv]
// Host processor model: kicks the watchdog and counts resets it receives
`timescale 1ns/10ps
module host_model #(
    parameter int KICK_PERIOD = 1000
) (
    input wire logic i_clk,
    input wire logic i_kick_en,
    input wire logic i_reset_out_oe_n,
    output logic o_kick,
    output logic [7:0] o_reset_cnt
);
    logic reset_q;
    int cnt;
    initial begin
        o_kick = 1'b0;
        o_reset_cnt = 8'h00;
        reset_q = 1'b1;
        cnt = 0;
    end
    // Open-drain reset line: pull-up gives high when released
    always @(posedge i_clk) begin
        reset_q <= i_reset_out_oe_n;
        if (reset_q && !i_reset_out_oe_n) begin
            o_reset_cnt <= o_reset_cnt + 8'h01;
        end
        cnt <= (cnt + 1) % KICK_PERIOD;
        // Either edge restarts the count, so a plain toggle suffices
        if (i_kick_en && cnt == 0) begin
            o_kick <= !o_kick;
        end
    end
endmodule : host_model

// [dv/rtc_supervisor_assertions.sv]
// Port-level checks for the supervisor block
`timescale 1ns/10ps
module rtc_supervisor_assertions #(
    parameter int REC_CYCLES = 50
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic i_supply_ok,
    input wire logic i_external_reset_input_n,
    input wire logic i_power_fail_input_ok,
    input wire logic o_reset_out_oe_n,
    input wire logic o_power_fail_output_n,
    input wire logic o_interrupt_test_level_pin_oe_n
);
    int low_cnt;
    int ext_cnt;
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            low_cnt <= 0;
            ext_cnt <= 0;
        end else begin
            low_cnt <= o_reset_out_oe_n ? 0 : low_cnt + 1;
            ext_cnt <= i_external_reset_input_n ? 0 : ext_cnt + 1;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    a_ready_one_cycle: assert property (o_pready |=> !o_pready)
        else $error("pready longer than one cycle");
    a_setup_ready: assert property (i_psel && !i_penable |=> o_pready)
        else $error("no pready after setup cycle");
    a_err_with_ready: assert property (o_pslverr |-> o_pready)
        else $error("pslverr without pready");
    a_fail_reset_low: assert property (!i_supply_ok [*8] |-> !o_reset_out_oe_n)
        else $error("reset not low during supply fail");
    a_pfo_forced_high: assert property (
        !i_supply_ok [*8] ##1 i_supply_ok [*8] |-> o_power_fail_output_n)
        else $error("power-fail output not forced high on return");
    a_pfo_follow_low: assert property (
        (o_reset_out_oe_n && !i_power_fail_input_ok) [*8] |-> !o_power_fail_output_n)
        else $error("power-fail output ignores low comparator");
    a_pfo_follow_high: assert property (
        (o_reset_out_oe_n && i_supply_ok && i_power_fail_input_ok) [*8]
        |-> o_power_fail_output_n)
        else $error("power-fail output ignores high comparator");
    a_rec_length: assert property (
        $rose(o_reset_out_oe_n) |-> low_cnt >= REC_CYCLES - 1)
        else $error("reset pulse shorter than recovery time");
    a_ext_reset_held: assert property (
        $rose(i_external_reset_input_n) && ext_cnt >= 60 |-> ##8 !o_reset_out_oe_n)
        else $error("long external reset gave no reset");
    c_reset_end: cover property ($rose(o_reset_out_oe_n) && i_supply_ok);
    c_slverr: cover property (o_pslverr);
    c_pin_low: cover property ($fell(o_interrupt_test_level_pin_oe_n));
endmodule : rtc_supervisor_assertions

bind rtc_supervisor rtc_supervisor_assertions #(.REC_CYCLES(REC_CYCLES)) chk (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_psel(i_psel), .i_penable(i_penable),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_supply_ok(i_supply_ok),
    .i_external_reset_input_n(i_external_reset_input_n),
    .i_power_fail_input_ok(i_power_fail_input_ok), .o_reset_out_oe_n(o_reset_out_oe_n),
    .o_power_fail_output_n(o_power_fail_output_n),
    .o_interrupt_test_level_pin_oe_n(o_interrupt_test_level_pin_oe_n));

// [dv/rtc_supervisor_test.sv]
// Self-checking bench for the supervisor block
`timescale 1ns/10ps
`include "rtc_sup_map.svh"
module rtc_supervisor_test;
    logic clk;
    logic nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic supply_ok = 1'b1, ext_rst_n = 1'b1, pfi_ok = 1'b1, kick_en = 1'b0, alarm = 1'b0;
    logic kick, pready, pslverr, pin_oe_n, rst_oe_n, pfo_n, square_wave_pin, rerr;
    logic [31:0] prdata, rdat;
    logic [7:0] rst_cnt, c0, d;
    int seed = 32'h24DE;
    int error_cnt = 0;
    int num_checks = 0;
    int k;
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    rtc_supervisor #(.REC_CYCLES(50), .OSC_DIV(4)) uut (
        .i_clk(clk), .i_nrst(nrst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_supply_ok(supply_ok),
        .i_external_reset_input_n(ext_rst_n), .i_watchdog_kick_input(kick),
        .i_power_fail_input_ok(pfi_ok), .i_alarm_flag(alarm),
        .o_interrupt_test_level_pin_out(), .o_interrupt_test_level_pin_oe_n(pin_oe_n),
        .o_reset_out_oe_n(rst_oe_n), .o_power_fail_output_n(pfo_n),
        .o_square_wave_pin(square_wave_pin), .o_second_tick());
    host_model host (.i_clk(clk), .i_kick_en(kick_en), .i_reset_out_oe_n(rst_oe_n),
        .o_kick(kick), .o_reset_cnt(rst_cnt));
    task automatic print_verdict();
        $display("checks=%0d errors=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : print_verdict
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] dat);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, dat};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            check({31'h0, pready}, 32'h1);
            print_verdict();
        end
        @(posedge clk);
    endtask : apb
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        check(rdat, {24'h0, e});
    endtask : rchk
    task automatic wait_lvl(input bit pin, input logic lvl, input int lim);
        int n;
        n = 0;
        while ((pin ? pin_oe_n : rst_oe_n) !== lvl && n < lim) begin
            @(posedge clk);
            n++;
        end
        if (n == lim) begin
            check({31'h0, !lvl}, {31'h0, lvl});
            print_verdict();
        end
    endtask : wait_lvl
    task automatic count_edges(input bit pin, input int cyc);
        logic prev;
        k = 0;
        prev = pin ? pin_oe_n : square_wave_pin;
        repeat (cyc) begin
            @(posedge clk);
            if ((pin ? pin_oe_n : square_wave_pin) && !prev) k++;
            prev = pin ? pin_oe_n : square_wave_pin;
        end
    endtask : count_edges
    // 2048 cycles hold 512 oscillator ticks at the shortened divider
    function automatic int exp_edges(input int code);
        return code == 0 ? 0 : (code == 1 ? 512 : 512 >> code);
    endfunction : exp_edges
    task automatic near(input int e);
        check({31'h0, k >= e - 1 && k <= e + 1}, 32'h1);
    endtask : near
    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        wait_lvl(0, 1'b1, 300);
        rchk(`OFS_WDOG, 8'h00);
        rchk(`OFS_TRIM, `TRIM_RESET);
        rchk(`OFS_AUX, {`AUX_RESET, 4'h0});
        rchk(`OFS_STATUS, 8'h00);
        apb(1'b0, 8'h04, 8'h00);
        check({rerr, rdat[30:0]}, 32'h80000000);
        repeat (4) begin
            d = 8'($random(seed));
            apb(1'b1, `OFS_TRIM, d);
            rchk(`OFS_TRIM, d);
        end
        apb(1'b1, `OFS_AUX, 8'h40);
        for (int c = 0; c < 8; c++) begin
            apb(1'b1, `OFS_RATE, 8'(c << 4));
            count_edges(0, 2048);
            near(exp_edges(c));
        end
        apb(1'b1, `OFS_AUX, 8'h00);
        count_edges(0, 2048);
        check(k, 0);
        apb(1'b1, `OFS_TRIM, 8'h80);
        repeat (6) @(posedge clk);
        check({31'h0, pin_oe_n}, 32'h1);
        apb(1'b1, `OFS_TRIM, 8'h00);
        repeat (6) @(posedge clk);
        check({31'h0, pin_oe_n}, 32'h0);
        apb(1'b1, `OFS_AUX, 8'h80);
        repeat (6) @(posedge clk);
        check({31'h0, pin_oe_n}, 32'h1);
        alarm <= 1'b1;
        repeat (6) @(posedge clk);
        check({31'h0, pin_oe_n}, 32'h0);
        rchk(`OFS_FLAGS, 8'h40);
        alarm <= 1'b0;
        apb(1'b1, `OFS_AUX, 8'h00);
        // Full positive trim must leave the test rate untouched
        apb(1'b1, `OFS_TRIM, 8'h7F);
        count_edges(1, 2048);
        near(8);
        apb(1'b1, `OFS_WDOG, 8'h04);
        // Let the last test-rate level drain from the pin register
        repeat (2) @(posedge clk);
        wait_lvl(1, 1'b0, 20000);
        count_edges(1, 300);
        check(k, 0);
        rchk(`OFS_FLAGS, 8'h80);
        rchk(`OFS_FLAGS, 8'h00);
        apb(1'b1, `OFS_WDOG, 8'h00);
        count_edges(1, 2048);
        near(8);
        apb(1'b1, `OFS_AUX, 8'hE0);
        apb(1'b1, `OFS_TRIM, 8'h40);
        c0 = rst_cnt;
        kick_en <= 1'b1;
        apb(1'b1, `OFS_WDOG, 8'h84);
        repeat (20000) @(posedge clk);
        check(rst_cnt, c0);
        kick_en <= 1'b0;
        wait_lvl(0, 1'b0, 20000);
        wait_lvl(0, 1'b1, 300);
        check(rst_cnt, c0 + 8'h01);
        rchk(`OFS_FLAGS, 8'h80);
        rchk(`OFS_WDOG, 8'h00);
        rchk(`OFS_AUX, 8'h00);
        rchk(`OFS_TRIM, 8'h00);
        apb(1'b1, `OFS_TRIM, 8'h40);
        supply_ok <= 1'b0;
        repeat (20) @(posedge clk);
        check({30'h0, rst_oe_n, pfo_n}, 32'h0);
        supply_ok <= 1'b1;
        wait_lvl(0, 1'b1, 300);
        apb(1'b0, `OFS_TRIM, 8'h00);
        check({31'h0, rdat[`TRIM_FT_BIT]}, 32'h0);
        rchk(`OFS_WDOG, 8'h00);
        pfi_ok <= 1'b0;
        repeat (12) @(posedge clk);
        check({31'h0, pfo_n}, 32'h0);
        pfi_ok <= 1'b1;
        ext_rst_n <= 1'b0;
        repeat (60) @(posedge clk);
        ext_rst_n <= 1'b1;
        repeat (8) @(posedge clk);
        check({31'h0, rst_oe_n}, 32'h0);
        wait_lvl(0, 1'b1, 300);
        ext_rst_n <= 1'b0;
        repeat (2 + {$random(seed)} % 8) @(posedge clk);
        ext_rst_n <= 1'b1;
        repeat (20) @(posedge clk);
        check({31'h0, rst_oe_n}, 32'h1);
        print_verdict();
    end
endmodule : rtc_supervisor_test

// [verilog/in_sync3.sv]
// Three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module in_sync3 #(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_async,
    output logic o_level
);
    typedef struct packed {
        logic [2:0] sh;
        logic lvl;
    } sync_state_t;
    sync_state_t st;
    sync_state_t next_st;

    always_comb begin
        next_st = st;
        next_st.sh = {st.sh[1:0], i_async};
        // Stage 0 only feeds stage 1
        if (st.sh[1] == st.sh[2]) begin
            next_st.lvl = st.sh[2];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            st <= '{sh: {3{RESET_VAL}}, lvl: RESET_VAL};
        end else begin
            st <= next_st;
        end
    end
    assign o_level = st.lvl;
endmodule : in_sync3

// [verilog/rtc_sup_map.svh]
// Register offsets, field positions, reset values and timing counts
`ifndef RTC_SUP_MAP_SVH
`define RTC_SUP_MAP_SVH
`define IDX_TRIM 8'h08
`define IDX_WDOG 8'h09
`define IDX_AUX 8'h0A
`define IDX_FLAGS 8'h0F
`define IDX_RATE 8'h13
`define IDX_STATUS 8'h14
// Byte address is four times the register index
`define OFS_TRIM (`IDX_TRIM << 2)
`define OFS_WDOG (`IDX_WDOG << 2)
`define OFS_AUX (`IDX_AUX << 2)
`define OFS_FLAGS (`IDX_FLAGS << 2)
`define OFS_RATE (`IDX_RATE << 2)
`define OFS_STATUS (`IDX_STATUS << 2)
`define TRIM_MAG_LSB 0
`define TRIM_SIGN_BIT 5
`define TRIM_FT_BIT 6
`define TRIM_OUT_BIT 7
`define WDOG_STEER_BIT 7
// Aux keeps bits 7:4 of its word: AFE, SQUARE_WAVE_ENABLE, ABE, oscillator halt
`define AUX_SQUARE_WAVE_ENABLE_BIT 2
`define AUX_ABE_BIT 1
`define AUX_AFE_BIT 3
`define AUX_HALT_BIT 0
`define FLAGS_WDF_BIT 7
`define TRIM_RESET 8'h80
`define AUX_RESET 4'h1
`define CLK_HZ 250000000
`define OSC_HZ 32768
`define REC_TIME_MS 100
`define MIN_RST_NS 200
`define MIN_RST_CYC ((`MIN_RST_NS * 250 + 999) / 1000)
`define REC_CYC ((`REC_TIME_MS * 250000))
`endif

// [verilog/rtc_sup_pkg.sv]
// Types for the supervisor block
package rtc_sup_pkg;
    typedef enum logic [1:0] {
        res_sixteenth,
        res_quarter,
        res_one,
        res_four
    } timeout_resolution_t;
    typedef enum logic [1:0] {
        pwr_off,
        pwr_recover,
        pwr_run
    } pwr_state_t;
endpackage : rtc_sup_pkg

// [verilog/rtc_supervisor.sv]
// Watchdog, square wave, reset and power-fail supervisor with calibration
// What this block does
// - Timeout equals five-bit multiplier times resolution 1/16, 1/4, 1 or 4 s.
// - Unrestarted timeout sets watchdog flag and fires interrupt or reset.
// - Steering zero: timeout asserts the shared interrupt/test/level pin.
// - Steering one: timeout gives a low reset pulse of one recovery time.
// - Reset-steered timeout clears watchdog register, FT, AFE, ABE, SQUARE_WAVE_ENABLE.
// - Any kick input edge or watchdog register write restarts the count.
// - Writing 00h clears the interrupt and leaves the watchdog disabled.
// - Reading the flags register clears the watchdog flag in bit 7.
// - Power-up clears the watchdog register, watchdog starts disabled.
// - Watchdog interrupt outranks frequency test on the shared pin.
// - Shared pin follows output level only when watchdog, AFE, FT zero.
// - Rate field picks square wave: none, 32.768 kHz, then 8.192 kHz halving down to 1 Hz.
// - Square wave enable gates the square wave pin independent of rate.
// - Reset output low during supply fail and one recovery time after.
// - External reset low pulse acts like power cycle; short pulses ignored.
// - On power return power-fail output forced high for recovery time.
// - Trim register holds calibration magnitude bits 4-0 and sign bit 5.
// - Magnitude N modifies one second in each of first 2N of 64 minutes.
// - Correction blanks or splits pulses at the divide-by-256 stage.
// - Shared pin toggles 512 Hz under halt, FT, AFE, steering conditions.
// - Test frequency is taken ahead of the calibration correction.
// - Frequency-test bit clears on every power-down.
//
// Register access over APB was decided locally.
`timescale 1ns/10ps
`include "rtc_sup_map.svh"
module rtc_supervisor
    import rtc_sup_pkg::*;
#(
    parameter int REC_CYCLES = `REC_CYC,
    parameter int OSC_DIV = `CLK_HZ / `OSC_HZ
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_supply_ok,
    input wire logic i_external_reset_input_n,
    input wire logic i_watchdog_kick_input,
    input wire logic i_power_fail_input_ok,
    input wire logic i_alarm_flag,
    output logic o_interrupt_test_level_pin_out,
    output logic o_interrupt_test_level_pin_oe_n,
    output logic o_reset_out_oe_n,
    output logic o_power_fail_output_n,
    output logic o_square_wave_pin,
    output logic o_second_tick
);
    localparam int MIN_RST = `MIN_RST_CYC;

    // Below 4 the half-rate square wave has no room; the divider holds 16 bits
    if (REC_CYCLES < 1 || OSC_DIV < 4 || OSC_DIV > 65536) begin : g_bad_param
        $error("rtc_supervisor: bad parameter");
    end

    typedef struct packed {
        logic [7:0] trim;
        logic [7:0] wdog;
        logic [3:0] aux;
        logic [3:0] rate;
        logic watchdog_flag;
        logic wd_irq;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [15:0] osc_div;
        logic [14:0] chain;
        logic [7:0] cal_cnt;
        logic [5:0] sec_in_min;
        logic [5:0] minute;
        logic [15:0] sec_cnt;
        logic split_pend;
        logic sec_tick;
        logic [11:0] wd_cnt;
        logic [16:0] wd_pre;
        logic kick_d;
        pwr_state_t pwr;
        logic [31:0] rec_cnt;
        logic [7:0] external_reset_input_cnt;
        logic rst_oe_n;
        logic pfo_n;
        logic pin_out;
        logic pin_oe_n;
        logic square_wave_pin;
    } sup_state_t;

    sup_state_t st;
    sup_state_t next_st;
    logic supply_s;
    logic external_reset_input_s;
    logic kick_s;
    logic pfi_s;

    in_sync3 #(.RESET_VAL(1'b0)) u_sync_sup (
        .i_clk(i_clk), .i_nrst(i_nrst), .i_async(i_supply_ok), .o_level(supply_s));
    in_sync3 #(.RESET_VAL(1'b1)) u_sync_external_reset_input (
        .i_clk(i_clk), .i_nrst(i_nrst), .i_async(i_external_reset_input_n),
        .o_level(external_reset_input_s));
    in_sync3 #(.RESET_VAL(1'b0)) u_sync_kick (
        .i_clk(i_clk), .i_nrst(i_nrst), .i_async(i_watchdog_kick_input), .o_level(kick_s));
    in_sync3 #(.RESET_VAL(1'b0)) u_sync_pfi (
        .i_clk(i_clk), .i_nrst(i_nrst), .i_async(i_power_fail_input_ok), .o_level(pfi_s));

    logic osc_tick;
    logic fire;
    logic wr_acc;
    logic rd_acc;
    logic down;
    logic [11:0] wd_limit;
    logic wd_tick;
    logic wd_irq_on;
    logic ft_on;
    logic cal_active;
    logic [4:0] mag;

    always_comb begin
        next_st = st;
        osc_tick = (st.osc_div == 16'(OSC_DIV - 1));
        wr_acc = i_psel && i_penable && i_pwrite;
        rd_acc = i_psel && i_penable && !i_pwrite;
        down = !supply_s || (st.external_reset_input_cnt >= 8'(MIN_RST) && !external_reset_input_s);
        mag = st.trim[`TRIM_MAG_LSB +: 5];
        fire = 1'b0;
        next_st.sec_tick = 1'b0;

        // 32768 Hz timebase from the system clock
        next_st.osc_div = osc_tick ? 16'h0000 : st.osc_div + 16'h0001;
        if (osc_tick) begin
            next_st.chain = st.chain + 15'h0001;
        end

        // Calibrated seconds: correction at the divide-by-256 stage
        cal_active = (st.minute < {mag, 1'b0}) && (st.sec_in_min == 6'h00);
        if (osc_tick) begin
            next_st.cal_cnt = st.cal_cnt + 8'h01;
            if (st.cal_cnt == 8'hFF) begin
                // Negative: one 256-stage pulse blanked; positive: one split in two
                if (cal_active && !st.trim[`TRIM_SIGN_BIT] && !st.split_pend
                    && st.sec_cnt == 16'h0000) begin
                    next_st.split_pend = 1'b1;
                end else begin
                    next_st.sec_cnt = st.sec_cnt + 16'h0001;
                end
            end else if (st.cal_cnt == 8'h7F && cal_active && st.trim[`TRIM_SIGN_BIT]
                         && st.sec_cnt == 16'h0000 && !st.split_pend) begin
                next_st.sec_cnt = st.sec_cnt + 16'h0001;
                next_st.split_pend = 1'b1;
            end
            if (st.sec_cnt == 16'h007F && st.cal_cnt == 8'hFF) begin
                next_st.sec_cnt = 16'h0000;
                next_st.split_pend = 1'b0;
                next_st.sec_tick = 1'b1;
                next_st.sec_in_min = (st.sec_in_min == 6'h3B) ? 6'h00 : st.sec_in_min + 6'h01;
                if (st.sec_in_min == 6'h3B) begin
                    next_st.minute = st.minute + 6'h01;
                end
            end
        end

        // Prescaler restarts with the count, so a restart always buys a full period
        wd_tick = 1'b0;
        if (osc_tick) begin
            next_st.wd_pre = st.wd_pre + 17'h00001;
        end
        unique case (timeout_resolution_t'(st.wdog[1:0]))
            res_sixteenth: wd_tick = osc_tick && st.wd_pre[10:0] == 11'h7FF;
            res_quarter: wd_tick = osc_tick && st.wd_pre[12:0] == 13'h1FFF;
            res_one: wd_tick = osc_tick && st.wd_pre[14:0] == 15'h7FFF;
            res_four: wd_tick = osc_tick && st.wd_pre == 17'h1FFFF;
        endcase
        wd_limit = {7'h00, st.wdog[6:2]};
        next_st.kick_d = kick_s;
        if (st.wdog[6:2] != 5'h00 && !st.wd_irq) begin
            if (wd_tick) begin
                next_st.wd_cnt = st.wd_cnt + 12'h001;
            end
            if (wd_tick && st.wd_cnt + 12'h001 >= wd_limit) begin
                fire = 1'b1;
                next_st.wd_cnt = 12'h000;
            end
        end
        if (kick_s != st.kick_d) begin
            next_st.wd_cnt = 12'h000;
            next_st.wd_pre = 17'h00000;
        end
        if (fire) begin
            next_st.watchdog_flag = 1'b1;
            if (st.wdog[`WDOG_STEER_BIT]) begin
                next_st.wdog = 8'h00;
                next_st.trim[`TRIM_FT_BIT] = 1'b0;
                next_st.aux[`AUX_AFE_BIT] = 1'b0;
                next_st.aux[`AUX_ABE_BIT] = 1'b0;
                next_st.aux[`AUX_SQUARE_WAVE_ENABLE_BIT] = 1'b0;
                next_st.pwr = pwr_recover;
                next_st.rec_cnt = 32'h0;
            end else begin
                next_st.wd_irq = 1'b1;
            end
        end

        // APB slave: zero wait states
        next_st.pready = 1'b0;
        next_st.pslverr = 1'b0;
        if (i_psel && !i_penable) begin
            next_st.pready = 1'b1;
            // Error rides with pready so the master takes both at one edge
            next_st.pslverr = !(i_paddr inside {`OFS_TRIM, `OFS_WDOG, `OFS_AUX,
                `OFS_FLAGS, `OFS_RATE, `OFS_STATUS});
        end
        if (wr_acc && st.pready) begin
            unique case (i_paddr)
                `OFS_TRIM: next_st.trim = i_pwdata[7:0];
                `OFS_WDOG: begin
                    next_st.wdog = i_pwdata[7:0];
                    next_st.wd_cnt = 12'h000;
                    next_st.wd_pre = 17'h00000;
                    next_st.wd_irq = 1'b0;
                end
                `OFS_AUX: next_st.aux = i_pwdata[7:4];
                `OFS_RATE: next_st.rate = i_pwdata[7:4];
                `OFS_FLAGS, `OFS_STATUS: ;
                default: ;
            endcase
        end
        if (i_psel && !i_penable && !i_pwrite) begin
            unique case (i_paddr)
                `OFS_TRIM: next_st.prdata = {24'h0, st.trim};
                `OFS_WDOG: next_st.prdata = {24'h0, st.wdog};
                `OFS_AUX: next_st.prdata = {24'h0, st.aux, 4'h0};
                `OFS_FLAGS: next_st.prdata = {24'h0, st.watchdog_flag, i_alarm_flag, 6'h00};
                `OFS_RATE: next_st.prdata = {24'h0, st.rate, 4'h0};
                `OFS_STATUS: next_st.prdata = {26'h0, st.minute};
                default: next_st.prdata = 32'h0;
            endcase
        end
        if (rd_acc && st.pready && i_paddr == `OFS_FLAGS && !fire) begin
            next_st.watchdog_flag = 1'b0;
        end

        // External reset filter: short lows never qualify
        if (!external_reset_input_s) begin
            if (st.external_reset_input_cnt < 8'(MIN_RST)) begin
                next_st.external_reset_input_cnt = st.external_reset_input_cnt + 8'h01;
            end
        end else begin
            next_st.external_reset_input_cnt = 8'h00;
        end

        // Power sequencing
        unique case (st.pwr)
            pwr_off: begin
                next_st.rst_oe_n = 1'b0;
                next_st.pfo_n = 1'b0;
                if (!down) begin
                    next_st.pwr = pwr_recover;
                    next_st.rec_cnt = 32'h0;
                end
            end
            pwr_recover: begin
                next_st.rst_oe_n = 1'b0;
                next_st.pfo_n = 1'b1;
                next_st.rec_cnt = st.rec_cnt + 32'h1;
                if (st.rec_cnt == 32'(REC_CYCLES - 1)) begin
                    next_st.pwr = pwr_run;
                end
            end
            pwr_run: begin
                next_st.rst_oe_n = 1'b1;
                next_st.pfo_n = pfi_s;
            end
        endcase
        if (down) begin
            next_st.pwr = pwr_off;
            next_st.rst_oe_n = 1'b0;
            next_st.pfo_n = 1'b0;
            next_st.trim[`TRIM_FT_BIT] = 1'b0;
            next_st.wdog = 8'h00;
            next_st.wd_irq = 1'b0;
            next_st.wd_cnt = 12'h000;
            next_st.wd_pre = 17'h00000;
            next_st.aux[`AUX_AFE_BIT] = 1'b0;
            next_st.aux[`AUX_ABE_BIT] = 1'b0;
            next_st.aux[`AUX_SQUARE_WAVE_ENABLE_BIT] = 1'b0;
        end

        // Shared pin priority: watchdog, alarm, frequency test, level
        wd_irq_on = st.wd_irq && !st.wdog[`WDOG_STEER_BIT];
        ft_on = st.trim[`TRIM_FT_BIT] && !st.aux[`AUX_HALT_BIT] && !st.aux[`AUX_AFE_BIT]
                && (st.wdog[`WDOG_STEER_BIT] || st.wdog == 8'h00);
        if (wd_irq_on) begin
            next_st.pin_oe_n = 1'b0;
        end else if (st.aux[`AUX_AFE_BIT]) begin
            next_st.pin_oe_n = !i_alarm_flag;
        end else if (ft_on) begin
            next_st.pin_oe_n = st.chain[5];
        end else if (st.wdog == 8'h00 && !st.trim[`TRIM_FT_BIT]) begin
            next_st.pin_oe_n = st.trim[`TRIM_OUT_BIT];
        end else begin
            next_st.pin_oe_n = 1'b1;
        end
        next_st.pin_out = 1'b0;

        // Square wave from the uncorrected chain
        if (st.rate == 4'h1) begin
            next_st.square_wave_pin = st.osc_div < 16'(OSC_DIV / 2);
        end else if (st.rate == 4'h0) begin
            next_st.square_wave_pin = 1'b0;
        end else begin
            next_st.square_wave_pin = st.chain[st.rate - 4'h1];
        end
        if (!st.aux[`AUX_SQUARE_WAVE_ENABLE_BIT]) begin
            next_st.square_wave_pin = 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            st <= '0;
            st.trim <= `TRIM_RESET;
            st.aux <= `AUX_RESET;
            st.pwr <= pwr_off;
            st.rst_oe_n <= 1'b0;
            st.pin_oe_n <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign o_prdata = st.prdata;
    assign o_pready = st.pready;
    assign o_pslverr = st.pslverr;
    assign o_interrupt_test_level_pin_out = st.pin_out;
    assign o_interrupt_test_level_pin_oe_n = st.pin_oe_n;
    assign o_reset_out_oe_n = st.rst_oe_n;
    assign o_power_fail_output_n = st.pfo_n;
    assign o_square_wave_pin = st.square_wave_pin;
    assign o_second_tick = st.sec_tick;
endmodule : rtc_supervisor
